// File: alert_pkg.sv
// Constants shared by the alert response and output enable block
package alert_pkg;
   // APB register offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_FAULT  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CMDS   = 8'h0C;
   localparam logic [7:0] OFS_DUTY   = 8'h10;
   localparam logic [7:0] OFS_VREF   = 8'h14;
   // Management bus command codes and alert response address
   localparam logic [7:0] CMD_OPERATION  = 8'h01;
   localparam logic [7:0] CMD_ON_OFF     = 8'h02;
   localparam logic [7:0] CMD_CLEAR      = 8'h03;
   localparam logic [7:0] CMD_VREF_TRIM  = 8'hD4;
   localparam logic [7:0] CMD_STEP_HIGH  = 8'hD5;
   localparam logic [7:0] CMD_STEP_LOW   = 8'hD6;
   localparam logic [7:0] CMD_ALERT_MASK = 8'hE7;
   localparam logic [6:0] ARA_ADDR       = 7'h0C;
   // Reset values; own address value is arbitrary
   localparam logic [7:0]  OPERATION_RST  = 8'h00;
   localparam logic [7:0]  ON_OFF_RST     = 8'h16;
   localparam logic [15:0] ALERT_MASK_RST = 16'h0000;
   localparam logic [6:0]  OWN_ADDR_RST   = 7'h24;
   localparam logic [7:0]  DUTY_RST       = 8'h28;
   localparam logic [11:0] VREF_NOM_MV    = 12'h258;
   // Field positions
   localparam int OP_ON_BIT      = 7;
   localparam int OP_MARGIN_LSB  = 4;
   localparam int ONOFF_CMD_BIT  = 3;
   localparam int ONOFF_PIN_BIT  = 2;
   localparam int ONOFF_POL_BIT  = 1;
   localparam int MASK_AUTO_OFF  = 8;
   localparam int MASK_PERSIST   = 0;
   localparam int FLT_ONCE_BIT   = 0;
   localparam int FLT_PERSIST    = 1;
   localparam int ST_ALERT_BIT   = 0;
   localparam int ST_ENABLE_BIT  = 1;
   localparam int ST_AUTO_BIT    = 2;
   localparam int ST_FAULT_LSB   = 4;
   // Margin field codes
   localparam logic [1:0] MARGIN_NONE = 2'h0;
   localparam logic [1:0] MARGIN_LOW  = 2'h1;
   localparam logic [1:0] MARGIN_HIGH = 2'h2;
   localparam logic [1:0] MARGIN_ALT  = 2'h3;
   // Switching timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SW_PERIOD_NS  = 800;
   localparam logic [7:0] SW_PERIOD_CYC = 8'(SW_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [7:0] RAMP_CYCLES   = 8'h80;
endpackage : alert_pkg

// File: sync2.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;
   sync_s r_r, r_nxt;

   // Only the second stage is visible outside
   always_comb begin
      r_nxt.s1 = d;
      r_nxt.s2 = r_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign q = r_r.s2;
endmodule : sync2

// File: pwm_ramp.sv
// Fixed-frequency switch timing with low-side soft ramp
`timescale 1ns/1ns
module pwm_ramp
   import alert_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       en,
   input  wire logic [7:0] duty,
   output logic            hs_on,
   output logic            ls_on
);
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] ramp;
      logic       hs;
      logic       ls;
   } pwm_s;
   pwm_s r_r, r_nxt;

   // Period counter, ramp counter and gate drive
   always_comb begin
      logic [7:0]  off_len;
      logic [15:0] prod;
      logic [7:0]  ls_len;
      logic        in_hs;
      off_len = SW_PERIOD_CYC - duty;
      prod    = off_len * r_r.ramp;
      ls_len  = prod[14:7];
      in_hs   = r_r.cnt < duty;
      r_nxt   = r_r;
      if (!en) begin
         r_nxt = '0;
      end else begin
         // [R8] Fixed period
         if (r_r.cnt == SW_PERIOD_CYC - 8'h01) begin
            r_nxt.cnt = 8'h00;
            if (r_r.ramp != RAMP_CYCLES) begin
               r_nxt.ramp = r_r.ramp + 8'h01;
            end
         end else begin
            r_nxt.cnt = r_r.cnt + 8'h01;
         end
         r_nxt.hs = in_hs;
         // [R9] Ramp low-side width
         r_nxt.ls = !in_hs && ((r_r.cnt - duty) < ls_len);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign hs_on = r_r.hs;
   assign ls_on = r_r.ls;
endmodule : pwm_ramp

// File: alert_ctrl.sv
// Alert signalling, alert response, output enable and margin control
// Operation
// [R1] Auto release default; mask bit 8 disables
// [R2] Fault pulls shared alert line low
// [R3] Answer alert address read only when alerting
// [R4] Clear faults releases alert after one-shot fault
// [R5] Standard mode: persistent fault re-flags at once
// [R6] Persistent fault holds alert until masked, cleared
// [R7] Auto mode releases alert after alert read
// [R8] Fixed switching frequency, any load
// [R9] Low-side on-time ramps over 128 cycles
// [R10] Pin mode: pin alone decides enable
// [R11] Pin polarity high or low selectable
// [R12] Command mode: operation alone decides
// [R13] Combined mode: pin and command both
// [R14] Margin none: nominal plus trim
// [R15] Margin low: subtract low step
// [R16] Margin high: add high step
// [R17] Works at 100 and 400 kHz
// [R18] Host avoids general call address zero
// [R19] Clear faults zeroes status, releases alert
// [R20] On/off config resets to 16h
// [R21] Two-bit margin field updated per write
// [R22] Enable decision recomputed from all inputs
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module alert_ctrl
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        smb_clk,
   input  wire logic        smb_data_i,
   output logic             smb_data_o,
   output logic             smb_data_oe,
   output logic             smb_alert_o,
   output logic             smb_alert_oe,
   input  wire logic        enable_input_pin,
   input  wire logic        fault_active,
   output logic             reg_enable,
   output logic [11:0]      vref_code,
   output logic             hs_drive,
   output logic             ls_drive
);
   import alert_pkg::*;

   typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_WAIT} smb_e;

   typedef struct packed {
      smb_e        st;
      logic        addr_ph;
      logic        rd;
      logic        is_ara;
      logic        wr_act;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [1:0]  nbytes;
      logic [7:0]  cmd;
      logic [7:0]  d0;
      logic [7:0]  d1;
      logic        scl_q;
      logic        sda_q;
      logic        sda_oe;
      logic        alert_oe;
      logic        pin_lvl;
      logic [7:0]  operation;
      logic [7:0]  on_off;
      logic [15:0] mask;
      logic [7:0]  trim;
      logic [7:0]  step_hi;
      logic [7:0]  step_lo;
      logic [6:0]  own_addr;
      logic [7:0]  duty;
      logic [1:0]  fault;
      logic        reg_en;
      logic [11:0] vref;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ctl_s;

   ctl_s       r_r, r_nxt;
   logic [2:0] pins_sync;

   // Bus lines and control pin cross into pclk here
   sync2 #(.W(3)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({enable_input_pin, smb_data_i, smb_clk}),
      .q     (pins_sync)
   );

   // Switch timing follows the registered enable
   pwm_ramp u_pwm (
      .clk   (pclk),
      .rst_n (presetn),
      .en    (r_r.reg_en),
      .duty  (r_r.duty),
      .hs_on (hs_drive),
      .ls_on (ls_drive)
   );

   always_comb begin
      logic        scl;
      logic        sda;
      logic        pin;
      logic        scl_rise;
      logic        scl_fall;
      logic        start;
      logic        stop;
      logic        clr;
      logic        once;
      logic        ara_done;
      logic        apb_evt;
      logic        setup;
      logic        wr;
      logic        hit;
      logic [1:0]  set;
      logic [1:0]  kept;
      logic        pin_on;
      logic        op_on;
      logic [11:0] base;
      logic [7:0]  byte_in;
      scl      = pins_sync[0];
      sda      = pins_sync[1];
      pin      = pins_sync[2];
      scl_rise = scl && !r_r.scl_q;
      scl_fall = !scl && r_r.scl_q;
      start    = scl && r_r.scl_q && r_r.sda_q && !sda;
      stop     = scl && r_r.scl_q && !r_r.sda_q && sda;
      clr      = 1'b0;
      once     = 1'b0;
      ara_done = 1'b0;
      byte_in  = r_r.shreg;
      r_nxt    = r_r;
      r_nxt.scl_q = scl;
      r_nxt.sda_q = sda;

      // [R17] Oversampled bus, no clock stretching needed
      if (start) begin
         r_nxt.st      = S_RX;
         r_nxt.addr_ph = 1'b1;
         r_nxt.bitcnt  = 4'h0;
         r_nxt.nbytes  = 2'h0;
         r_nxt.wr_act  = 1'b0;
         r_nxt.sda_oe  = 1'b0;
      end else if (stop) begin
         r_nxt.st     = S_IDLE;
         r_nxt.sda_oe = 1'b0;
         r_nxt.wr_act = 1'b0;
         // Commands act only once the whole write has ended
         if (r_r.wr_act && r_r.nbytes != 2'h0) begin
            unique case (r_r.cmd)
               // [R4] Clear on command
               CMD_CLEAR: clr = 1'b1;
               CMD_OPERATION: begin
                  // [R21] Margin field follows write
                  if (r_r.nbytes >= 2'h2) r_nxt.operation = r_r.d0;
               end
               CMD_ON_OFF: begin
                  if (r_r.nbytes >= 2'h2) r_nxt.on_off = r_r.d0;
               end
               CMD_VREF_TRIM: begin
                  if (r_r.nbytes >= 2'h2) r_nxt.trim = r_r.d0;
               end
               CMD_STEP_HIGH: begin
                  if (r_r.nbytes >= 2'h2) r_nxt.step_hi = r_r.d0;
               end
               CMD_STEP_LOW: begin
                  if (r_r.nbytes >= 2'h2) r_nxt.step_lo = r_r.d0;
               end
               CMD_ALERT_MASK: begin
                  if (r_r.nbytes == 2'h3) r_nxt.mask = {r_r.d1, r_r.d0};
               end
               // Unknown code counts as a one-time fault
               default: once = 1'b1;
            endcase
         end
      end else begin
         unique case (r_r.st)
            S_IDLE, S_WAIT: begin
            end
            S_RX: begin
               if (scl_rise && r_r.bitcnt != 4'h8) begin
                  r_nxt.shreg  = {r_r.shreg[6:0], sda};
                  r_nxt.bitcnt = r_r.bitcnt + 4'h1;
               end else if (scl_fall && r_r.bitcnt == 4'h8) begin
                  r_nxt.st      = S_ACK;
                  r_nxt.sda_oe  = 1'b1;
                  r_nxt.addr_ph = 1'b0;
                  r_nxt.bitcnt  = 4'h0;
                  if (r_r.addr_ph) begin
                     r_nxt.is_ara = 1'b0;
                     r_nxt.rd     = byte_in[0];
                     r_nxt.wr_act = !byte_in[0];
                     r_nxt.shreg  = {6'h00, r_r.fault};
                     if (byte_in[7:1] == r_r.own_addr) begin
                     // [R3] Answer alert address only when alerting
                     end else if (byte_in[7:1] == ARA_ADDR && byte_in[0]
                                  && r_r.alert_oe) begin
                        r_nxt.is_ara = 1'b1;
                        r_nxt.shreg  = {r_r.own_addr, 1'b1};
                     end else begin
                        r_nxt.st     = S_WAIT;
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.wr_act = 1'b0;
                     end
                  end else begin
                     // Bytes beyond two data bytes (such as PEC) are dropped
                     unique case (r_r.nbytes)
                        2'h0: r_nxt.cmd = byte_in;
                        2'h1: r_nxt.d0  = byte_in;
                        2'h2: r_nxt.d1  = byte_in;
                        2'h3: begin
                        end
                     endcase
                     if (r_r.nbytes != 2'h3) r_nxt.nbytes = r_r.nbytes + 2'h1;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  if (r_r.rd) begin
                     r_nxt.st     = S_TX;
                     r_nxt.sda_oe = !r_r.shreg[7];
                     r_nxt.shreg  = {r_r.shreg[6:0], 1'b1};
                     r_nxt.bitcnt = 4'h1;
                  end else begin
                     r_nxt.st     = S_RX;
                     r_nxt.sda_oe = 1'b0;
                  end
               end
            end
            S_TX: begin
               // Released line read low means another device won arbitration
               if (scl_rise && !r_r.sda_oe && !sda) begin
                  r_nxt.st = S_WAIT;
               end else if (scl_fall) begin
                  if (r_r.bitcnt == 4'h8) begin
                     r_nxt.st     = S_TXACK;
                     r_nxt.sda_oe = 1'b0;
                  end else begin
                     r_nxt.sda_oe = !r_r.shreg[7];
                     r_nxt.shreg  = {r_r.shreg[6:0], 1'b1};
                     r_nxt.bitcnt = r_r.bitcnt + 4'h1;
                  end
               end
            end
            S_TXACK: begin
               // Further read bytes return all ones
               if (scl_rise) begin
                  ara_done = r_r.is_ara;
                  r_nxt.st = S_WAIT;
               end
            end
         endcase
      end

      // APB slave: answer one cycle after setup
      setup = psel && !penable;
      hit   = paddr == OFS_CONFIG || paddr == OFS_FAULT || paddr == OFS_STATUS
              || paddr == OFS_CMDS || paddr == OFS_DUTY || paddr == OFS_VREF;
      wr    = psel && penable && r_r.pready && pwrite && !r_r.pslverr;
      r_nxt.pready  = setup;
      r_nxt.pslverr = setup && !hit;
      if (setup) begin
         unique case (paddr)
            OFS_CONFIG: r_nxt.prdata = {25'h0000000, r_r.own_addr};
            OFS_STATUS: r_nxt.prdata = {26'h0000000, r_r.fault, 1'b0,
                                        !r_r.mask[MASK_AUTO_OFF],
                                        r_r.reg_en, r_r.alert_oe};
            OFS_CMDS:   r_nxt.prdata = {r_r.mask, r_r.on_off, r_r.operation};
            OFS_DUTY:   r_nxt.prdata = {24'h000000, r_r.duty};
            OFS_VREF:   r_nxt.prdata = {r_r.step_hi, r_r.step_lo, 4'h0, r_r.vref};
            default:    r_nxt.prdata = 32'h00000000;
         endcase
      end
      apb_evt = wr && paddr == OFS_FAULT && pwdata[0];
      if (wr && paddr == OFS_CONFIG) r_nxt.own_addr = pwdata[6:0];
      if (wr && paddr == OFS_DUTY) r_nxt.duty = pwdata[7:0];

      // [R5] Persistent fault sets again even during a clear
      set = '0;
      set[FLT_ONCE_BIT] = once || apb_evt;
      set[FLT_PERSIST]  = fault_active && !r_r.mask[MASK_PERSIST];
      kept = clr ? 2'h0 : r_r.fault;
      // [R19] Clear zeroes status, new set wins
      r_nxt.fault = kept | set;
      // [R2] New fault drives alert low
      if (|(set & ~kept)) begin
         r_nxt.alert_oe = 1'b1;
      // [R6] A clear releases only when no new fault sets
      end else if (clr) begin
         r_nxt.alert_oe = 1'b0;
      // [R1] Auto release unless mask bit disables
      end else if (ara_done && !r_r.mask[MASK_AUTO_OFF]) begin
         // [R7] Release after alert read
         r_nxt.alert_oe = 1'b0;
      end

      // [R11] Pin polarity
      pin_on = r_r.on_off[ONOFF_POL_BIT] ? pin : !pin;
      op_on  = r_r.operation[OP_ON_BIT];
      // [R22] Enable from pin, command and mode
      unique case ({r_r.on_off[ONOFF_CMD_BIT], r_r.on_off[ONOFF_PIN_BIT]})
         // [R10] Pin only
         2'b01: r_nxt.reg_en = pin_on;
         // [R12] Command only
         2'b10: r_nxt.reg_en = op_on;
         // [R13] Both required
         2'b11: r_nxt.reg_en = pin_on && op_on;
         2'b00: r_nxt.reg_en = 1'b1;
      endcase

      // [R14] Nominal plus signed trim
      base = VREF_NOM_MV + {{4{r_r.trim[7]}}, r_r.trim};
      unique case (r_r.operation[OP_MARGIN_LSB +: 2])
         // [R15] Low margin step
         MARGIN_LOW:  r_nxt.vref = base - {4'h0, r_r.step_lo};
         // [R16] High margin step
         MARGIN_HIGH: r_nxt.vref = base + {4'h0, r_r.step_hi};
         MARGIN_NONE, MARGIN_ALT: r_nxt.vref = base;
      endcase
   end

   // Single state register; reset values are constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r           <= '0;
         r_r.st        <= S_IDLE;
         r_r.scl_q     <= 1'b1;
         r_r.sda_q     <= 1'b1;
         r_r.operation <= OPERATION_RST;
         // [R20] Pin-only, active-high default
         r_r.on_off    <= ON_OFF_RST;
         r_r.mask      <= ALERT_MASK_RST;
         r_r.own_addr  <= OWN_ADDR_RST;
         r_r.duty      <= DUTY_RST;
         r_r.vref      <= VREF_NOM_MV;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign prdata       = r_r.prdata;
   assign pready       = r_r.pready;
   assign pslverr      = r_r.pslverr;
   assign smb_data_o   = r_r.pin_lvl;
   assign smb_data_oe  = r_r.sda_oe;
   assign smb_alert_o  = r_r.pin_lvl;
   assign smb_alert_oe = r_r.alert_oe;
   assign reg_enable   = r_r.reg_en;
   assign vref_code    = r_r.vref;
endmodule : alert_ctrl

// File: alert_checker.sv
// Port-level assertions for the alert block
`timescale 1ns/1ns
module alert_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        smb_data_o,
   input wire logic        smb_data_oe,
   input wire logic        smb_alert_o,
   input wire logic        smb_alert_oe,
   input wire logic        enable_input_pin,
   input wire logic        reg_enable,
   input wire logic [11:0] vref_code,
   input wire logic        hs_drive,
   input wire logic        ls_drive
);
   import alert_pkg::*;
   // One domain: clock and reset given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Zero wait states, single pulse
   a_ready_next: assert property (psel && !penable |=> pready) else $error("pready late");
   a_ready_once: assert property (pready |=> !pready) else $error("pready held");
   a_slverr_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_VREF))
      else $error("pslverr wrong");
   a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
   a_alert_low: assert property (smb_alert_oe |-> !smb_alert_o) else $error("alert not low");
   a_data_low: assert property (smb_data_oe |-> !smb_data_o) else $error("data not low");
   a_no_overlap: assert property (!(hs_drive && ls_drive)) else $error("both switches on");
   a_off_quiet: assert property (!reg_enable [*4] |-> !hs_drive && !ls_drive)
      else $error("switching while off");
   a_vref_start: assert property ($rose(presetn) |-> vref_code == VREF_NOM_MV)
      else $error("vref not nominal");
   a_pin_start: assert property ($rose(presetn) && enable_input_pin |-> ##[1:6] reg_enable)
      else $error("pin did not enable");
   // Main scenarios
   c_alert_on: cover property ($rose(smb_alert_oe));
   c_alert_off: cover property ($fell(smb_alert_oe));
   c_slverr: cover property (pslverr);
   c_enable: cover property ($rose(reg_enable));
endmodule : alert_checker

// File: smb_host.sv
// Management bus host model; data line has a pull-up, host drives the clock
`timescale 1ns/1ns
module smb_host
   import alert_pkg::*;
(
   input  wire logic pclk,
   input  wire logic dev_pull,
   output logic      scl,
   output logic      sda
);
   logic host_low = 1'b0;
   // Clock stands high between frames
   initial scl = 1'b1;
   // Released line reads high
   assign sda = !(host_low || dev_pull);
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask : w
   task automatic bit_out(input logic b);
      w(3);
      host_low <= !b;
      w(7);
      scl <= 1'b1;
      w(10);
      scl <= 1'b0;
   endtask : bit_out
   task automatic bit_in(output logic s);
      w(3);
      host_low <= 1'b0;
      w(7);
      scl <= 1'b1;
      w(5);
      s = sda;
      w(5);
      scl <= 1'b0;
   endtask : bit_in
   task automatic byte_out(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      bit_in(s);
      ack = !s;
   endtask : byte_out
   task automatic start_c;
      w(10);
      host_low <= 1'b1;
      w(10);
      scl <= 1'b0;
   endtask : start_c
   task automatic stop_c;
      w(3);
      host_low <= 1'b1;
      w(7);
      scl <= 1'b1;
      w(10);
      host_low <= 1'b0;
      w(10);
   endtask : stop_c
   task automatic write(input logic [7:0] cmd, input logic [15:0] d, input logic [1:0] n);
      logic a;
      start_c();
      byte_out({OWN_ADDR_RST, 1'b0}, a);
      byte_out(cmd, a);
      if (n > 2'h0) byte_out(d[7:0], a);
      if (n > 2'h1) byte_out(d[15:8], a);
      stop_c();
   endtask : write
   task automatic ara(output logic ack, output logic [7:0] b);
      logic s;
      b = 8'hFF;
      start_c();
      byte_out({ARA_ADDR, 1'b1}, ack);
      if (ack) begin
         for (int i = 0; i < 8; i++) begin
            bit_in(s);
            b = {b[6:0], s};
         end
         bit_out(1'b1);
      end
      stop_c();
   endtask : ara
endmodule : smb_host

// File: tb_top.sv
// Self-checking bench for the alert and output enable block
`timescale 1ns/1ns
module tb_top;
   import alert_pkg::*;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_s;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'hE;
   logic        pready, pslverr, scl, sda, smb_data_o, smb_data_oe, smb_alert_o, smb_alert_oe;
   logic        enable_input_pin = 1'b1, fault_active = 1'b0, reg_enable, hs_drive, ls_drive;
   logic [11:0] vref_code;
   logic [5:0]  t, l, h;
   note_s       notes[$];
   int          err_total = 0, checked = 0;
   // Rows: on/off config, operation on, pin, expected enable
   logic [10:0] en_tab [11] = '{11'h0B3, 11'h0B0, 11'h0B4, 11'h0A1, 11'h0A2, 11'h0D5,
                                11'h0D2, 11'h0F7, 11'h0F4, 11'h0F2, 11'h091};
   // Clock at 125 MHz
   always #4 pclk = !pclk;
   alert_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .smb_clk(scl), .smb_data_i(sda), .smb_data_o(smb_data_o),
      .smb_data_oe(smb_data_oe), .smb_alert_o(smb_alert_o), .smb_alert_oe(smb_alert_oe),
      .enable_input_pin(enable_input_pin), .fault_active(fault_active),
      .reg_enable(reg_enable), .vref_code(vref_code), .hs_drive(hs_drive), .ls_drive(ls_drive));
   smb_host u_host (.pclk(pclk), .dev_pull(smb_data_oe), .scl(scl), .sda(sda));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction : xs
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cmp_rd(input note_s n, input logic [31:0] d, input logic e);
      checked++;
      if ((d & n.m) !== n.d || e !== n.e) begin
         err_total++;
         $display("wrong value prdata expected %h %b seen %h %b", n.d, n.e, d & n.m, e);
      end
   endtask : cmp_rd
   // Held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      notes.push_back('{d, m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic st(input logic a);
      repeat (6) @(posedge pclk);
      rd(OFS_STATUS, {31'h0, a}, 32'h1, 1'b0);
   endtask : st
   task automatic ara_chk(input logic a);
      logic       k;
      logic [7:0] b;
      u_host.ara(k, b);
      chk("ara ack", {31'h0, a}, {31'h0, k});
      if (a) chk("ara address", 32'h49, {24'h0, b});
   endtask : ara_chk
   task automatic mrg(input logic [1:0] m, input logic [11:0] e);
      u_host.write(CMD_OPERATION, {8'h00, 2'h2, m, 4'h0}, 2'h1);
      repeat (8) @(posedge pclk);
      chk("vref_code", {20'h0, e}, {20'h0, vref_code});
   endtask : mrg
   task automatic clr;
      u_host.write(CMD_CLEAR, 16'h0, 2'h0);
   endtask : clr
   // Each completed read takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp_rd(notes.pop_front(), prdata, pslverr);
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      err_total++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      rd(OFS_CMDS, 32'h1600, 32'hFFFFFFFF, 1'b0);
      rd(OFS_STATUS, 32'h6, 32'h37, 1'b0);
      rd(8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, 8'h40, 32'h7F);
      rd(OFS_CONFIG, 32'h24, 32'h7F, 1'b0);
      seed = xs(seed);
      apb(1'b1, OFS_DUTY, {26'h0, seed[5:0]});
      rd(OFS_DUTY, {26'h0, seed[5:0]}, 32'hFF, 1'b0);
      ara_chk(1'b0);
      apb(1'b1, OFS_FAULT, 32'h1);
      st(1'b1);
      ara_chk(1'b1);
      st(1'b0);
      clr();
      rd(OFS_STATUS, 32'h6, 32'h37, 1'b0);
      u_host.write(CMD_ALERT_MASK, 16'h0100, 2'h2);
      rd(OFS_STATUS, 32'h0, 32'h4, 1'b0);
      apb(1'b1, OFS_FAULT, 32'h1);
      ara_chk(1'b1);
      st(1'b1);
      clr();
      st(1'b0);
      fault_active <= 1'b1;
      st(1'b1);
      ara_chk(1'b1);
      clr();
      st(1'b1);
      u_host.write(CMD_ALERT_MASK, 16'h0101, 2'h2);
      clr();
      st(1'b0);
      fault_active <= 1'b0;
      u_host.write(CMD_ALERT_MASK, 16'h0000, 2'h2);
      clr();
      fault_active <= 1'b1;
      st(1'b1);
      ara_chk(1'b1);
      st(1'b0);
      fault_active <= 1'b0;
      clr();
      // Every enable mode; both pin levels except in the always-on mode
      for (int i = 0; i < 11; i++) begin
         u_host.write(CMD_ON_OFF, {8'h00, en_tab[i][10:3]}, 2'h1);
         u_host.write(CMD_OPERATION, {8'h00, en_tab[i][2], 7'h00}, 2'h1);
         enable_input_pin <= en_tab[i][1];
         repeat (8) @(posedge pclk);
         chk("reg_enable", {31'h0, en_tab[i][0]}, {31'h0, reg_enable});
      end
      // Random trim and steps
      seed = xs(seed);
      t = seed[5:0] & 6'h1F;
      l = seed[13:8];
      h = seed[21:16];
      u_host.write(CMD_VREF_TRIM, {10'h0, t}, 2'h1);
      u_host.write(CMD_STEP_HIGH, {10'h0, h}, 2'h1);
      u_host.write(CMD_STEP_LOW, {10'h0, l}, 2'h1);
      mrg(MARGIN_NONE, 12'h258 + {6'h0, t});
      u_host.write(CMD_VREF_TRIM, 16'h0, 2'h1);
      mrg(MARGIN_LOW, 12'h258 - {6'h0, l});
      mrg(MARGIN_HIGH, 12'h258 + {6'h0, h});
      rd(OFS_VREF, {2'h0, h, 2'h0, l, 4'h0, 12'h258 + {6'h0, h}}, 32'hFFFF0FFF, 1'b0);
      print_verdict();
   end
endmodule : tb_top
bind alert_ctrl alert_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .smb_data_o(smb_data_o), .smb_data_oe(smb_data_oe), .smb_alert_o(smb_alert_o),
   .smb_alert_oe(smb_alert_oe), .enable_input_pin(enable_input_pin),
   .reg_enable(reg_enable), .vref_code(vref_code), .hs_drive(hs_drive), .ls_drive(ls_drive));
